//--- core_idle_cfg.svh
/*
 holds the numeric constants of the core idle and performance-state controller.
 assumes inclusion by bare name from the package and design modules.
*/
`ifndef CORE_IDLE_CFG_SVH
`define CORE_IDLE_CFG_SVH
`define THREADS 2
`define CORES 2
`define PST_W 4
`define IO_ADDR_W 16
`define DWELL_W 8
`define DWELL_DEFAULT 8'h10
`define FLUSH_CYCLES 4'h4
`define SAVE_CYCLES 4'h4
`define RESTORE_CYCLES 4'h4
`define STEP_W 4
`define LVL2_OFFSET 16'h0000
`define LVL3_OFFSET 16'h0001
`define SUBSTATE_ZERO 4'h0
`endif

//--- core_idle_ctrl.sv
/*
 per-core idle resolution, wake handling and shared performance-state control.
 assumes all inputs synchronous to clock_i and per-thread requests single-cycle pulses issued from C0.
*/
`timescale 1ns/1ps
`include "core_idle_cfg.svh"
// Function
// - core idle level is lowest level requested by its threads
// - interrupt, or monitor hit after mwait entry, returns core to C0
// - thread and core idle transitions always pass through C0
// - power actions start only after the core level is resolved
// - core resolves to C1E once every active core is C1 or deeper
// - redirected legacy idle reads become internal requests, no system read
// - level two read maps to C3, level three read to C6
// - reads outside capture range pass through as ordinary port reads
// - redirected requests always carry substate zero
// - redirected requests wake on interrupts even when masked
// - raising frequency commands voltage first, locks pll after
// - lowering frequency locks pll first, then commands lower voltage
// - shared frequency is highest level requested by any active core
// - new performance request preempts a transition in progress
// - C1 entered only when every thread has halted or requested C1
// - in C1 or C3 a targeted interrupt wakes only its thread
// - any package interrupt may wake a core; targeted wakes only target
// - a C1 core keeps servicing snoops
// - C3 entry flushes caches, keeps state, stops core clocks
// - snoops and foreign cacheable accesses never wake a C3 core
// - C6 saves state before dropping voltage, restores on exit
module core_idle_ctrl
	import core_idle_pkg::*;
(
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic [`THREADS*`CORES-1:0] thr_req_i,
	input wire logic [`THREADS*`CORES*3-1:0] thr_state_i,
	input wire logic [`THREADS*`CORES-1:0] thr_masked_i,
	input wire logic [`THREADS*`CORES-1:0] thr_irq_i,
	input wire logic [`THREADS*`CORES-1:0] thr_mwait_i,
	input wire logic package_irq_i,
	input wire logic [`CORES-1:0] monitor_hit_i,
	input wire logic [`CORES-1:0] snoop_i,
	input wire logic [`CORES-1:0] core_active_i,
	input wire logic ddc_en_i,
	input wire logic [`DWELL_W-1:0] dwell_i,
	input wire logic redirect_en_i,
	input wire logic [`IO_ADDR_W-1:0] capture_base_i,
	input wire logic [`IO_ADDR_W-1:0] capture_limit_i,
	input wire logic io_read_i,
	input wire logic [`IO_ADDR_W-1:0] io_addr_i,
	input wire logic [1:0] io_thread_i,
	input wire logic [`CORES*`PST_W-1:0] core_pst_i,
	input wire logic vid_done_i,
	input wire logic pll_lock_i,
	output logic io_passthru_o,
	output logic [`CORES*3-1:0] core_state_o,
	output logic [`THREADS*`CORES-1:0] thr_awake_o,
	output logic [`CORES-1:0] c1e_o,
	output logic [`CORES-1:0] clk_stop_o,
	output logic [`CORES-1:0] flush_o,
	output logic [`CORES-1:0] save_o,
	output logic [`CORES-1:0] restore_o,
	output logic [`CORES-1:0] power_off_o,
	output logic [`CORES-1:0] snoop_ack_o,
	output logic vid_cmd_o,
	output logic [`PST_W-1:0] vid_level_o,
	output logic pll_req_o,
	output logic [`PST_W-1:0] pll_freq_o
);
	localparam int N = `THREADS * `CORES;
	localparam int T = `THREADS;

	logic rd_req;
	cstate_t rd_state;
	logic [3:0] rd_sub;
	logic [`PST_W-1:0] pst_max;
	cstate_t thr_q [N];
	logic [N-1:0] redir_q;
	logic [N-1:0] mw_q;
	core_seq_t seq_q [`CORES];
	cstate_t goal_q [`CORES];
	cstate_t res [`CORES];
	logic [`DWELL_W-1:0] dwell_q [`CORES];
	logic [3:0] step_q [`CORES];
	logic [`CORES-1:0] all_idle, wake;
	logic [`CORES-1:0] deep_ok;

	io_redirect u_redir (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.redirect_en_i(redirect_en_i),
		.capture_base_i(capture_base_i),
		.capture_limit_i(capture_limit_i),
		.io_read_i(io_read_i),
		.io_addr_i(io_addr_i),
		.req_o(rd_req),
		.req_state_o(rd_state),
		.req_sub_o(rd_sub),
		.passthru_o(io_passthru_o)
	);

	// highest requested level across active cores drives the shared step
	always_comb
	begin
		pst_max = '0;
		for (int c = 0; c < `CORES; c++)
			if (core_active_i[c] && core_pst_i[c*`PST_W +: `PST_W] > pst_max)
				pst_max = core_pst_i[c*`PST_W +: `PST_W];
	end

	pstate_seq u_pseq (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.target_i(pst_max),
		.vid_done_i(vid_done_i),
		.pll_lock_i(pll_lock_i),
		.vid_cmd_o(vid_cmd_o),
		.vid_level_o(vid_level_o),
		.pll_req_o(pll_req_o),
		.pll_freq_o(pll_freq_o),
		.cur_o()
	);

	// thread-level state: requests land only from C0, wakes drop to C0
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			for (int t = 0; t < N; t++)
				thr_q[t] <= CST_C0;
			redir_q <= '0;
			mw_q <= '0;
		end
		else
		begin
			for (int t = 0; t < N; t++)
			begin
				// masked interrupts still wake a redirected request
				if (thr_irq_i[t] && (!thr_masked_i[t] || redir_q[t]))
				begin
					thr_q[t] <= CST_C0;
					redir_q[t] <= 1'b0;
				end
				else if (monitor_hit_i[t/T] && mw_q[t] && thr_q[t] != CST_C0)
					thr_q[t] <= CST_C0;
				else if (thr_q[t] == CST_C0 && rd_req && io_thread_i == t[1:0]
					&& rd_sub == `SUBSTATE_ZERO)
				begin
					thr_q[t] <= rd_state;
					redir_q[t] <= 1'b1;
					mw_q[t] <= 1'b1;
				end
				else if (thr_q[t] == CST_C0 && thr_req_i[t])
				begin
					thr_q[t] <= cstate_t'(thr_state_i[t*3 +: 3]);
					mw_q[t] <= thr_mwait_i[t];
				end
			end
		end
	end

	// resolution: min over threads; all threads idle needed for C1
	always_comb
	begin
		for (int c = 0; c < `CORES; c++)
		begin
			res[c] = CST_C6;
			for (int k = 0; k < T; k++)
				res[c] = cmin(res[c], thr_q[c*T+k]);
			all_idle[c] = res[c] != CST_C0;
			wake[c] = package_irq_i || (res[c] == CST_C0);
			deep_ok[c] = !ddc_en_i || dwell_q[c] == '0;
		end
	end

	// per-core sequence; actions follow resolved level only
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			for (int c = 0; c < `CORES; c++)
			begin
				seq_q[c] <= CS_RUN;
				goal_q[c] <= CST_C0;
				dwell_q[c] <= '0;
				step_q[c] <= '0;
			end
		end
		else
		begin
			for (int c = 0; c < `CORES; c++)
			begin
				step_q[c] <= (step_q[c] == '0) ? '0 : step_q[c] - 4'h1;
				case (seq_q[c])
					CS_RUN: if (all_idle[c])
					begin
						seq_q[c] <= CS_HALT;
						goal_q[c] <= res[c];
						dwell_q[c] <= ddc_en_i ? dwell_i : '0;
					end
					CS_HALT: if (wake[c]) seq_q[c] <= CS_RUN;
						else if (res[c] != CST_C1) seq_q[c] <= CS_DWELL;
					CS_DWELL: if (wake[c]) seq_q[c] <= CS_RUN;
						else if (deep_ok[c])
						begin
							seq_q[c] <= CS_FLUSH;
							step_q[c] <= `FLUSH_CYCLES;
						end
						else dwell_q[c] <= dwell_q[c] - 8'h01;
					CS_FLUSH: if (step_q[c] == '0)
					begin
						seq_q[c] <= (res[c] == CST_C6) ? CS_SAVE : CS_DEEP;
						step_q[c] <= `SAVE_CYCLES;
					end
					CS_SAVE: if (step_q[c] == '0) seq_q[c] <= CS_DEEP;
					CS_DEEP: if (wake[c])
					begin
						seq_q[c] <= CS_WAKE;
						step_q[c] <= `RESTORE_CYCLES;
					end
					CS_WAKE: if (step_q[c] == '0) seq_q[c] <= CS_RUN;
					default: seq_q[c] <= CS_RUN;
				endcase
			end
		end
	end

	// outputs registered from sequence state
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			core_state_o <= '0;
			thr_awake_o <= '1;
			c1e_o <= '0;
			clk_stop_o <= '0;
			flush_o <= '0;
			save_o <= '0;
			restore_o <= '0;
			power_off_o <= '0;
			snoop_ack_o <= '0;
		end
		else
		begin
			for (int t = 0; t < N; t++)
				thr_awake_o[t] <= thr_q[t] == CST_C0;
			for (int c = 0; c < `CORES; c++)
			begin
				// a deeper goal reads as run until committed, so the visible level never
				// steps sideways from C1 into C3 or C6; only the delayed dwell shows C1
				core_state_o[c*3 +: 3] <= (seq_q[c] == CS_DEEP || seq_q[c] == CS_WAKE) ? goal_q[c] :
					((seq_q[c] != CS_RUN && goal_q[c] == CST_C1)
					|| (seq_q[c] == CS_DWELL && ddc_en_i)) ? CST_C1 : CST_C0;
				c1e_o[c] <= (seq_q[c] != CS_RUN) && ((all_idle | ~core_active_i) == '1);
				clk_stop_o[c] <= seq_q[c] != CS_RUN && seq_q[c] != CS_WAKE;
				flush_o[c] <= seq_q[c] == CS_FLUSH;
				save_o[c] <= seq_q[c] == CS_SAVE;
				restore_o[c] <= seq_q[c] == CS_WAKE && goal_q[c] == CST_C6;
				power_off_o[c] <= seq_q[c] == CS_DEEP && goal_q[c] == CST_C6;
				// halted cores still answer snoops; deep cores hold flushed caches
				snoop_ack_o[c] <= snoop_i[c] && (seq_q[c] == CS_RUN
					|| seq_q[c] == CS_HALT || seq_q[c] == CS_DWELL);
			end
		end
	end

	save_first_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		seq_q[0] == CS_FLUSH && step_q[0] == '0 && res[0] == CST_C6 |=> seq_q[0] == CS_SAVE)
		else $error("c6 skipped save");
	snoop_nowake_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		seq_q[0] == CS_DEEP && !wake[0] |=> seq_q[0] == CS_DEEP) else $error("deep core woke");
	c1_halt_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		seq_q[0] == CS_RUN && !all_idle[0] |=> seq_q[0] == CS_RUN) else $error("halt with thread active");
	dwell_hold_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		seq_q[0] == CS_DWELL && !wake[0] && !deep_ok[0] |=> seq_q[0] == CS_DWELL) else $error("dwell cut short");
endmodule

//--- core_idle_pkg.sv
/*
 types shared by the idle controller and its helpers.
 assumes core_idle_cfg.svh is reachable by bare name.
*/
`include "core_idle_cfg.svh"
package core_idle_pkg;
	// idle levels, numerically ordered so that min selects the shallowest
	typedef enum logic [2:0] {
		CST_C0 = 3'h0,
		CST_C1 = 3'h1,
		CST_C3 = 3'h3,
		CST_C6 = 3'h6
	} cstate_t;

	// core sequencing states, one bit apart from run through halt, dwell, flush and save to deep
	typedef enum logic [2:0] {
		CS_RUN = 3'h0,
		CS_HALT = 3'h1,
		CS_DWELL = 3'h3,
		CS_FLUSH = 3'h2,
		CS_SAVE = 3'h6,
		CS_DEEP = 3'h7,
		CS_WAKE = 3'h5
	} core_seq_t;

	// performance step sequencing
	typedef enum logic [1:0] {
		PS_IDLE = 2'h0,
		PS_VOLT = 2'h1,
		PS_PLL = 2'h3,
		PS_VDOWN = 2'h2
	} pstep_t;

	function automatic cstate_t cmin(input cstate_t a, input cstate_t b);
		cmin = (a < b) ? a : b;
	endfunction
endpackage

//--- io_redirect.sv
/*
 converts legacy idle-level port reads into idle requests with substate zero.
 assumes reads are single-cycle strobes synchronous to clock_i.
*/
`timescale 1ns/1ps
`include "core_idle_cfg.svh"
module io_redirect
	import core_idle_pkg::*;
(
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic redirect_en_i,
	input wire logic [`IO_ADDR_W-1:0] capture_base_i,
	input wire logic [`IO_ADDR_W-1:0] capture_limit_i,
	input wire logic io_read_i,
	input wire logic [`IO_ADDR_W-1:0] io_addr_i,
	output logic req_o,
	output cstate_t req_state_o,
	output logic [3:0] req_sub_o,
	output logic passthru_o
);
	// decode of the two level registers and the range check
	wire logic is_lvl2 = io_addr_i == capture_base_i + `LVL2_OFFSET;
	wire logic is_lvl3 = io_addr_i == capture_base_i + `LVL3_OFFSET;
	wire logic in_range = (io_addr_i >= capture_base_i) && (io_addr_i <= capture_limit_i);
	wire logic hit = redirect_en_i && in_range && (is_lvl2 || is_lvl3);

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			req_o <= 1'b0;
			req_state_o <= CST_C0;
			req_sub_o <= `SUBSTATE_ZERO;
			passthru_o <= 1'b0;
		end
		else
		begin
			req_o <= io_read_i && hit;
			req_state_o <= is_lvl3 ? CST_C6 : CST_C3;
			req_sub_o <= `SUBSTATE_ZERO;
			passthru_o <= io_read_i && !hit;
		end
	end

	// a redirected hit must never leak out as a system read
	no_leak_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		io_read_i && hit |=> req_o && !passthru_o) else $error("redirected read leaked");
	range_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		io_read_i && !in_range |=> !req_o) else $error("out of range read redirected");
endmodule

//--- pstate_seq.sv
/*
 orders voltage and pll steps for a performance-state change.
 assumes the regulator acknowledges each voltage command with vid_done_i.
*/
`timescale 1ns/1ps
`include "core_idle_cfg.svh"
module pstate_seq
	import core_idle_pkg::*;
(
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic [`PST_W-1:0] target_i,
	input wire logic vid_done_i,
	input wire logic pll_lock_i,
	output logic vid_cmd_o,
	output logic [`PST_W-1:0] vid_level_o,
	output logic pll_req_o,
	output logic [`PST_W-1:0] pll_freq_o,
	output logic [`PST_W-1:0] cur_o
);
	pstep_t st_q, st_d;
	logic [`PST_W-1:0] goal_q;
	// any new target restarts the sequence, even mid-transition
	wire logic retarget = target_i != goal_q;
	wire logic up = target_i > cur_o;

	always_comb
	begin
		st_d = st_q;
		case (st_q)
			PS_IDLE: if (retarget || target_i != cur_o) st_d = up ? PS_VOLT : PS_PLL;
			PS_VOLT: if (retarget) st_d = up ? PS_VOLT : PS_PLL;
				else if (vid_done_i) st_d = PS_PLL;
			PS_PLL: if (retarget) st_d = up ? PS_VOLT : PS_PLL;
				else if (pll_lock_i) st_d = (goal_q < vid_level_o) ? PS_VDOWN : PS_IDLE;
			PS_VDOWN: if (retarget) st_d = up ? PS_VOLT : PS_PLL;
				else if (vid_done_i) st_d = PS_IDLE;
			default: st_d = PS_IDLE;
		endcase
	end

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			st_q <= PS_IDLE;
			goal_q <= '0;
			cur_o <= '0;
			vid_level_o <= '0;
			pll_freq_o <= '0;
			vid_cmd_o <= 1'b0;
			pll_req_o <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			goal_q <= target_i;
			vid_cmd_o <= (st_d == PS_VOLT) || (st_d == PS_VDOWN);
			pll_req_o <= st_d == PS_PLL;
			if (st_d == PS_VOLT || st_d == PS_VDOWN)
				vid_level_o <= target_i;
			if (st_d == PS_PLL)
				pll_freq_o <= target_i;
			if (st_q == PS_PLL && pll_lock_i && !retarget)
				cur_o <= goal_q;
		end
	end

	// raising: pll is never asked before the voltage step finishes
	volt_first_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		st_q == PS_VOLT && !vid_done_i && !retarget |=> st_q == PS_VOLT) else $error("pll before voltage");
	pll_first_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		st_q == PS_IDLE && target_i < cur_o && !retarget |=> st_q == PS_PLL) else $error("lowering skipped pll");
endmodule

//--- tb.sv
/*
 self-checking bench for the core idle and performance-state controller.
 assumes two cores of two threads and the regulator stand-in beside it.
*/
`timescale 1ns/1ps
`include "core_idle_cfg.svh"
module tb
	import core_idle_pkg::*;
;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [3:0] thr_req_i = '0, thr_masked_i = '0, thr_irq_i = '0, thr_mwait_i = '0;
	logic [11:0] thr_state_i = '0;
	logic package_irq_i = 1'b0, ddc_en_i = 1'b0, redirect_en_i = 1'b0, io_read_i = 1'b0;
	logic [1:0] monitor_hit_i = '0, snoop_i = '0, core_active_i = 2'h3, io_thread_i = '0;
	logic [7:0] dwell_i = 8'h10, core_pst_i = '0;
	logic [15:0] capture_base_i = 16'h0410, capture_limit_i = 16'h0411, io_addr_i = '0;
	logic vid_done_i, pll_lock_i, vid_cmd_o, pll_req_o, io_passthru_o, slow = 1'b0;
	logic [5:0] core_state_o;
	logic [3:0] thr_awake_o, vid_level_o, pll_freq_o, cur = 4'h0;
	logic [1:0] c1e_o, clk_stop_o, flush_o, save_o, restore_o, power_off_o, snoop_ack_o;
	logic [1:0] first = '0;
	logic [5:0] seen = '0;
	logic [2:0] prev [2];
	int errors = 0, checks_done = 0, pt_cnt = 0, n;

	always #12.5 clock_i = ~clock_i;

	core_idle_ctrl core_idle_ctrl_i (.*);
	vreg_model vreg_model_i (.clock_i(clock_i), .rstn_i(rstn_i), .slow_i(slow),
		.vid_cmd_i(vid_cmd_o), .pll_req_i(pll_req_o), .vid_done_o(vid_done_i),
		.pll_lock_o(pll_lock_i));

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input bit ok, input string msg);
		checks_done++;
		if (!ok)
		begin
			errors++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask

	task automatic req(input int t, input cstate_t st, input bit mw);
		@(posedge clock_i);
		thr_req_i[t] <= 1'b1;
		thr_state_i[t*3+:3] <= st;
		thr_mwait_i[t] <= mw;
		@(posedge clock_i);
		thr_req_i[t] <= 1'b0;
	endtask

	task automatic irq(input int t);
		@(posedge clock_i);
		thr_irq_i[t] <= 1'b1;
		@(posedge clock_i);
		thr_irq_i[t] <= 1'b0;
	endtask

	task automatic io(input int t, input logic [15:0] a);
		@(posedge clock_i);
		io_read_i <= 1'b1;
		io_addr_i <= a;
		io_thread_i <= t[1:0];
		@(posedge clock_i);
		io_read_i <= 1'b0;
	endtask

	// bounded wait for a core level, sampled mid-cycle
	task automatic wait_core(input int c, input cstate_t st);
		n = 0;
		while (core_state_o[c*3+:3] !== st && n < 200)
		begin
			@(negedge clock_i);
			n++;
		end
		chk(core_state_o[c*3+:3] === st, "core level not reached");
		if (n >= 200)
			close_out();
	endtask

	function automatic logic [3:0] pmax(input logic [7:0] lv, input logic [1:0] act);
		pmax = 4'h0;
		for (int c = 0; c < 2; c++)
			if (act[c] && lv[c*4+:4] > pmax)
				pmax = lv[c*4+:4];
	endfunction

	// perf change; the order of the first step depends on direction
	task automatic pst(input logic [7:0] lv, input logic [1:0] act);
		logic [3:0] e;
		e = pmax(lv, act);
		@(posedge clock_i);
		core_pst_i <= lv;
		core_active_i <= act;
		first = 2'b00;
		n = 0;
		while (!(pll_freq_o === e && vid_level_o === e && vid_cmd_o === 1'b0
			&& pll_req_o === 1'b0) && n < 300)
		begin
			@(negedge clock_i);
			n++;
		end
		chk(n < 300, "performance level not reached");
		if (e > cur)
			chk(first === 2'b01, "voltage not raised before pll");
		if (e < cur)
			chk(first === 2'b10, "pll not locked before voltage drop");
		cur = e;
		if (n >= 300)
			close_out();
	endtask

	// event monitors on settled values
	always @(posedge clock_i)
	begin
		pt_cnt <= pt_cnt + int'(io_passthru_o === 1'b1);
		seen <= seen | {power_off_o[0] & ~seen[1], restore_o[0], snoop_ack_o[0],
			power_off_o[0], save_o[0], flush_o[0]};
		if (first == 2'b00)
			first <= {pll_req_o === 1'b1, vid_cmd_o === 1'b1};
		for (int c = 0; c < 2; c++)
		begin
			if (rstn_i && !ddc_en_i && prev[c] != 3'h0 && core_state_o[c*3+:3] != 3'h0
				&& core_state_o[c*3+:3] != prev[c])
				chk(1'b0, "idle level changed without passing run");
			prev[c] = core_state_o[c*3+:3];
		end
	end

	initial
	begin
		void'($urandom(32'h76e3));
		repeat (20) @(posedge clock_i);
		rstn_i <= 1'b1;
		@(negedge clock_i);
		chk(core_state_o === 6'h0 && thr_awake_o === 4'hf && vid_cmd_o === 1'b0, "reset");
		$display("test reset done");
		// one thread deep, the other still running: no power action yet
		req(0, CST_C3, 1'b0);
		repeat (8) @(negedge clock_i);
		chk(core_state_o[2:0] === CST_C0 && clk_stop_o === 2'h0, "core left run early");
		req(1, CST_C1, 1'b0);
		wait_core(0, CST_C1);
		chk(c1e_o === 2'h0, "c1e with core 1 running");
		req(2, CST_C1, 1'b0);
		req(3, CST_C6, 1'b0);
		wait_core(1, CST_C1);
		repeat (4) @(negedge clock_i);
		chk(c1e_o === 2'h3, "c1e not set");
		@(posedge clock_i);
		snoop_i[0] <= 1'b1;
		@(posedge clock_i);
		snoop_i[0] <= 1'b0;
		repeat (4) @(negedge clock_i);
		chk(seen[3] === 1'b1 && core_state_o[2:0] === CST_C1, "snoop in halt");
		irq(0);
		wait_core(0, CST_C0);
		chk(thr_awake_o[1:0] === 2'b01, "only target thread woken");
		@(posedge clock_i);
		package_irq_i <= 1'b1;
		@(posedge clock_i);
		package_irq_i <= 1'b0;
		wait_core(1, CST_C0);
		irq(1);
		irq(2);
		irq(3);
		repeat (4) @(negedge clock_i);
		chk(thr_awake_o === 4'hf, "threads awake");
		$display("test halt and wake done");
		// redirected legacy reads, firmware sets range before first use
		@(posedge clock_i);
		capture_base_i <= 16'h0400 + 16'($urandom_range(0, 255)) * 16'h0010;
		redirect_en_i <= 1'b1;
		thr_masked_i <= 4'hf;
		@(posedge clock_i);
		capture_limit_i <= capture_base_i + 16'h0001;
		seen = '0;
		pt_cnt = 0;
		io(0, capture_base_i);
		io(1, capture_base_i);
		wait_core(0, CST_C3);
		repeat (4) @(negedge clock_i);
		chk(seen[0] === 1'b1 && clk_stop_o[0] === 1'b1 && pt_cnt == 0, "deep sleep entry");
		@(posedge clock_i);
		snoop_i[0] <= 1'b1;
		@(posedge clock_i);
		snoop_i[0] <= 1'b0;
		repeat (6) @(negedge clock_i);
		chk(core_state_o[2:0] === CST_C3, "snoop woke deep core");
		irq(1);
		wait_core(0, CST_C0);
		chk(thr_awake_o[1:0] === 2'b10, "masked wake of thread");
		irq(0);
		io(0, capture_base_i + 16'h0002);
		repeat (4) @(negedge clock_i);
		chk(pt_cnt == 1 && thr_awake_o === 4'hf, "out of range read");
		seen = '0;
		io(0, capture_base_i + 16'h0001);
		io(1, capture_base_i + 16'h0001);
		wait_core(0, CST_C6);
		repeat (6) @(negedge clock_i);
		chk(seen[1] === 1'b1 && seen[2] === 1'b1 && seen[5] === 1'b0, "save before off");
		@(posedge clock_i);
		package_irq_i <= 1'b1;
		@(posedge clock_i);
		package_irq_i <= 1'b0;
		wait_core(0, CST_C0);
		chk(seen[4] === 1'b1, "state restore on exit");
		irq(0);
		irq(1);
		thr_masked_i <= 4'h0;
		$display("test redirect done");
		// monitored address wakes an mwait core
		req(2, CST_C1, 1'b1);
		req(3, CST_C1, 1'b1);
		wait_core(1, CST_C1);
		@(posedge clock_i);
		monitor_hit_i[1] <= 1'b1;
		@(posedge clock_i);
		monitor_hit_i[1] <= 1'b0;
		wait_core(1, CST_C0);
		irq(2);
		irq(3);
		$display("test monitor done");
		// delayed deep idle: dwell then commit, and an abort in the dwell
		for (int k = 0; k < 2; k++)
		begin
			@(posedge clock_i);
			ddc_en_i <= 1'b1;
			dwell_i <= 8'($urandom_range(12, 30));
			req(0, CST_C3, 1'b1);
			req(1, CST_C3, 1'b1);
			wait_core(0, CST_C1);
			repeat (8) @(negedge clock_i);
			chk(core_state_o[2:0] === CST_C1, "dwell too short");
			if (k == 1)
			begin
				irq(0);
				wait_core(0, CST_C0);
				irq(1);
			end
			else
			begin
				wait_core(0, CST_C3);
				irq(0);
				wait_core(0, CST_C0);
				irq(1);
			end
			repeat (4) @(negedge clock_i);
			ddc_en_i <= 1'b0;
		end
		$display("test delayed deep done");
		// performance levels: random steps, inactive core, preemption
		for (int k = 0; k < 8; k++)
		begin
			slow = 1'($urandom_range(0, 1));
			pst(8'($urandom), 2'($urandom_range(1, 3)));
		end
		pst(8'h3f, 2'h1);
		slow = 1'b1;
		@(posedge clock_i);
		core_pst_i <= 8'h0c;
		repeat (3) @(posedge clock_i);
		pst(8'h02, 2'h3);
		$display("test performance done");
		close_out();
	end

	initial
	begin
		#2500000;
		errors++;
		close_out();
	end
endmodule

//--- vreg_model.sv
/*
 voltage regulator and pll stand-in for the performance-state sequencer.
 assumes commands are levels held by the sequencer until acknowledged.
*/
`timescale 1ns/1ps
module vreg_model (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic slow_i,
	input wire logic vid_cmd_i,
	input wire logic pll_req_i,
	output logic vid_done_o,
	output logic pll_lock_o
);
	logic [3:0] vcnt_q;
	logic [3:0] pcnt_q;
	logic [3:0] lat;
	// slow mode leaves room for a preempting request mid-transition
	assign lat = slow_i ? 4'h9 : 4'h1;

	// count how long each request has stood, saturating
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			vcnt_q <= 4'h0;
			pcnt_q <= 4'h0;
		end
		else
		begin
			vcnt_q <= vid_cmd_i ? vcnt_q + {3'h0, vcnt_q != 4'hf} : 4'h0;
			pcnt_q <= pll_req_i ? pcnt_q + {3'h0, pcnt_q != 4'hf} : 4'h0;
		end
	end

	// acks drop as soon as the request goes away, never left standing
	assign vid_done_o = vid_cmd_i && vcnt_q >= lat;
	assign pll_lock_o = pll_req_i && pcnt_q >= lat;
endmodule
